// ---- logic/lmt_transcode.sv ----
// lane marker transcoder: 66b to 513b encoder and 513b to 66b decoder with bip transparency
//
// How it works
// - flag set when any control or marker row
// - marker rows share top rows with control rows
// - marker sync header dropped in the row
// - marker row kind code is 0100
// - slot index gives marker arrival position
// - more-rows bit flags further control rows
// - row carries tag bytes then pcs mask
// - decoder emits marker at its slot index
// - ingress pcs mask is expected xor received
// - ingress otn bip over unscrambled fixed data
// - egress rebuilds ingress marker with inverses
// - egress otn mask is expected xor carried
// - egress third parity over rescrambled stream
// - third parity xored with pcs, otn masks
// - seventh parity is inverse of third
// - egress scrambler starts from all-ones seed
// - bad sync header becomes error block
// - unknown or unused control type becomes error
// - error block is 10, 0x1e, /E/ chars
// - failed 513b decode gives eight error blocks
// - payloads scrambled skipping headers and markers
// - four lanes, tag-identified, separate bip state
`timescale 1ns/10ps
`include "lmt_regs.svh"

module lmt_transcode #(
  parameter logic [15:0][7:0] CTL_TYPES = {8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hE1, 8'hD2, 8'hCC,
                                           8'hB4, 8'hAA, 8'h99, 8'h00, 8'h87, 8'h4B, 8'h78, 8'h1E},
  parameter logic [15:0]      CTL_USED  = 16'h0FEF
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire lmt_pkg::lmt_blk_t in_blk,
  input  wire logic [63:0]      in_raw_pay,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output lmt_pkg::lmt_513_t     enc_blk,
  output logic                  enc_valid,
  input  wire logic             enc_ready,
  output logic                  ing_subst,
  input  wire lmt_pkg::lmt_513_t dec_blk,
  input  wire logic             dec_valid,
  output logic                  dec_ready,
  output lmt_pkg::lmt_blk_t     out_blk,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic                  dec_fail
);

  localparam logic [3:0][23:0] LANE_TAGS = {`LMT_TAG_LANE3, `LMT_TAG_LANE2, `LMT_TAG_LANE1, `LMT_TAG_LANE0};
  localparam lmt_pkg::lmt_blk_t ERR_BLK  = '{sh: `LMT_SH_CTRL, pay: {`LMT_ERR_CHARS, `LMT_ERR_TYPE}};

  // bip-8 fold of one block, sync bits first then payload bits
  function automatic logic [7:0] bip_fold(input lmt_pkg::lmt_blk_t b);
    logic [65:0] v;
    logic [7:0]  acc;
    v   = {b.pay, b.sh};
    acc = 8'h00;
    for (int j = 0; j < 66; j++) begin
      acc[(j + 6) % 8] = acc[(j + 6) % 8] ^ v[j];
    end
    return acc;
  endfunction

  // lane lookup from the three tag bytes: {hit, lane}
  function automatic logic [2:0] tag_lane(input logic [23:0] tag);
    logic [2:0] r;
    r = 3'h0;
    for (int l = 0; l < 4; l++) begin
      if (tag == LANE_TAGS[l]) begin
        r = {1'b1, 2'(l)};
      end
    end
    return r;
  endfunction

  // control type lookup: {known, code}
  function automatic logic [4:0] ctl_code(input logic [7:0] t);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (CTL_USED[i] && CTL_TYPES[i] == t) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // self-synchronous scrambler over 64 bits: {next state, output}
  function automatic logic [121:0] scramble(input logic [63:0] d, input logic [57:0] s);
    logic [57:0] st;
    logic [63:0] o;
    st = s;
    o  = 64'h0;
    for (int i = 0; i < 64; i++) begin
      o[i] = d[i] ^ st[`LMT_SCR_TAP_A - 1] ^ st[`LMT_SCR_TAP_B - 1];
      st   = {st[56:0], o[i]};
    end
    return {st, o};
  endfunction

  // decoded slot from a control or marker row
  function automatic lmt_pkg::lmt_slot_t row_slot(input logic [63:0] r);
    lmt_pkg::lmt_slot_t e;
    e.mark     = (r[`LMT_KIND_HI:0] == `LMT_KIND_MARKER);
    e.mask     = r[39:32];
    e.otn      = r[47:40];
    e.blk.sh   = `LMT_SH_CTRL;
    e.blk.pay  = {r[63:8], CTL_TYPES[r[`LMT_KIND_HI:0]]};
    if (e.mark) begin
      e.blk.pay = {~r[39:32], ~r[31:8], r[39:32], r[31:8]};
    end
    return e;
  endfunction

  // ---------------- ingress encoder ----------------
  lmt_pkg::lmt_slot_t slot [8];       // gathered slots of the block in progress
  lmt_pkg::lmt_slot_t gat  [8];       // slots with the incoming block merged in
  lmt_pkg::lmt_slot_t in_entry;       // incoming block as a slot
  lmt_pkg::lmt_513_t  next_enc;       // assembled 513b block
  logic [7:0]         ing_pcs [4];    // per-lane pcs bip sums
  logic [7:0]         ing_otn [4];    // per-lane otn bip sums
  logic [2:0]         icnt;           // slot index of the next block
  logic [1:0]         ing_lane;       // lane of the next non-marker block
  logic               take;           // incoming block accepted

  wire logic [2:0]    in_tag   = tag_lane(in_blk.pay[23:0]);
  wire logic          in_mark  = (in_blk.sh == `LMT_SH_CTRL) && in_tag[2] &&
                                 (in_blk.pay[55:32] == ~in_blk.pay[23:0]);
  wire logic [4:0]    in_code  = ctl_code(in_blk.pay[7:0]);
  wire logic          in_bad   = !((in_blk.sh == `LMT_SH_DATA) ||
                                   ((in_blk.sh == `LMT_SH_CTRL) && (in_mark || in_code[4])));
  wire lmt_pkg::lmt_blk_t in_fix = in_bad ? ERR_BLK : in_blk;
  wire logic [1:0]    in_lane  = in_mark ? in_tag[1:0] : ing_lane;
  wire lmt_pkg::lmt_blk_t in_raw = '{sh: in_blk.sh, pay: in_raw_pay};
  wire logic [7:0]    in_pfold = bip_fold(in_raw);
  wire logic [7:0]    in_ofold = bip_fold(in_fix);

  assign in_ready = !enc_valid || enc_ready;
  assign take     = in_valid && in_ready;

  // incoming block with its pcs error mask and otn bip when it is a marker
  always_comb begin
    in_entry.blk  = in_fix;
    in_entry.mark = in_mark;
    in_entry.mask = ing_pcs[in_lane] ^ in_blk.pay[31:24];
    in_entry.otn  = ing_otn[in_lane];
  end

  // merge incoming block into its slot for assembly
  always_comb begin
    for (int s = 0; s < 8; s++) begin
      gat[s] = (3'(s) == icnt) ? in_entry : slot[s];
    end
  end

  // assemble: control and marker rows on top in arrival order, then data
  always_comb begin
    logic [3:0] nctl;
    logic [3:0] r;
    logic [4:0] cc;
    nctl = 4'h0;
    r    = 4'h0;
    cc   = 5'h00;
    next_enc = '0;
    for (int s = 0; s < 8; s++) begin
      if (gat[s].blk.sh == `LMT_SH_CTRL) begin
        if (gat[s].mark) begin
          // tag bytes, pcs mask, otn bip; marker sync header is not carried
          next_enc.row[r[2:0]] = {16'h0000, gat[s].otn, gat[s].mask, gat[s].blk.pay[23:0],
                                  1'b0, 3'(s), `LMT_KIND_MARKER};
        end else begin
          // control row: payload bytes 1-7 kept, type byte replaced by its code
          cc = ctl_code(gat[s].blk.pay[7:0]);
          next_enc.row[r[2:0]] = {gat[s].blk.pay[63:8], 1'b0, 3'(s), cc[3:0]};
        end
        r    = r + 4'h1;
        nctl = nctl + 4'h1;
      end
    end
    for (int s = 0; s < 8; s++) begin
      if (gat[s].blk.sh != `LMT_SH_CTRL) begin
        next_enc.row[r[2:0]] = gat[s].blk.pay;
        r = r + 4'h1;
      end
    end
    for (int q = 0; q < 8; q++) begin
      if (4'(q) + 4'h1 < nctl) begin
        next_enc.row[q][`LMT_MORE_BIT] = 1'b1;
      end
    end
    next_enc.flag = (nctl != 4'h0);
  end

  // gather slots and present each full 513b block
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      icnt      <= 3'h0;
      ing_lane  <= 2'h0;
      enc_valid <= 1'b0;
      enc_blk   <= '0;
      ing_subst <= 1'b0;
      for (int s = 0; s < 8; s++) begin
        slot[s] <= '0;
      end
    end else begin
      ing_subst <= take && in_bad;
      if (enc_valid && enc_ready) begin
        enc_valid <= 1'b0;
      end
      if (take) begin
        slot[icnt] <= in_entry;
        icnt       <= icnt + 3'h1;
        ing_lane   <= in_lane + 2'h1;
        if (icnt == 3'h7) begin
          enc_blk   <= next_enc;
          enc_valid <= 1'b1;
        end
      end
    end
  end

  // ---------------- egress decoder ----------------
  lmt_pkg::lmt_state_t state;         // emit machine state
  lmt_pkg::lmt_slot_t  dslot [8];     // decoded slots awaiting emission
  lmt_pkg::lmt_slot_t  dsl   [8];     // decode of the offered block
  lmt_pkg::lmt_blk_t   fifo  [2];     // two-entry output buffer
  lmt_pkg::lmt_blk_t   emit_blk;      // processed block to buffer
  logic                dbad;          // offered block fails a check
  logic [2:0]          eidx;          // slot being emitted
  logic [1:0]          egr_lane;      // lane of the next non-marker block
  logic [57:0]         scr;           // egress scrambler state
  logic [7:0]          egr_pcs [4];   // per-lane egress pcs bip sums
  logic [7:0]          egr_otn [4];   // per-lane egress otn bip sums
  logic [1:0]          fcnt;          // buffer occupancy
  logic                fwr;           // buffer write pointer
  logic                frd;           // buffer read pointer

  assign dec_ready = (state == lmt_pkg::LMT_ST_IDLE);
  assign out_valid = (fcnt != 2'h0);
  assign out_blk   = fifo[frd];

  wire logic              fpop    = out_valid && out_ready;
  wire logic              emit_go = (state == lmt_pkg::LMT_ST_EMIT) && ((fcnt != 2'h2) || fpop);
  wire lmt_pkg::lmt_slot_t cur    = dslot[eidx];
  wire logic [2:0]        e_tag   = tag_lane(cur.blk.pay[23:0]);
  wire logic [1:0]        e_lane  = cur.mark ? e_tag[1:0] : egr_lane;
  wire logic [121:0]      e_scr   = scramble(cur.blk.pay, scr);
  wire logic [7:0]        e_ofold = bip_fold(cur.blk);
  wire logic [7:0]        otn_err = egr_otn[e_lane] ^ cur.otn;
  wire logic [7:0]        adj_par = (egr_pcs[e_lane] ^ cur.mask) ^ otn_err;
  wire logic [7:0]        e_pfold = bip_fold(emit_blk);

  // decode the offered 513b block and run the order checks
  always_comb begin
    logic [3:0] ncr;
    logic       done;
    logic       hit;
    logic [3:0] k;
    logic [3:0] di;
    ncr  = 4'h0;
    done = 1'b0;
    hit  = 1'b0;
    k    = 4'h0;
    di   = 4'h0;
    dbad = 1'b0;
    for (int s = 0; s < 8; s++) begin
      dsl[s] = '{blk: '{sh: `LMT_SH_DATA, pay: dec_blk.row[s]}, mark: 1'b0, mask: 8'h00, otn: 8'h00};
    end
    if (dec_blk.flag) begin
      for (int r = 0; r < 8; r++) begin
        if (!done) begin
          ncr  = ncr + 4'h1;
          done = !dec_blk.row[r][`LMT_MORE_BIT];
        end
      end
      dbad = !done;
      for (int r = 0; r < 8; r++) begin
        if (4'(r) < ncr && dec_blk.row[r][`LMT_KIND_HI:0] != `LMT_KIND_MARKER &&
            !CTL_USED[dec_blk.row[r][`LMT_KIND_HI:0]]) begin
          dbad = 1'b1;
        end
      end
      for (int r = 1; r < 8; r++) begin
        if (4'(r) < ncr &&
            dec_blk.row[r][`LMT_POS_HI:`LMT_POS_LO] <= dec_blk.row[r - 1][`LMT_POS_HI:`LMT_POS_LO]) begin
          dbad = 1'b1;
        end
      end
      for (int s = 0; s < 8; s++) begin
        k   = 4'h0;
        hit = 1'b0;
        for (int r = 0; r < 8; r++) begin
          if (4'(r) < ncr) begin
            if (dec_blk.row[r][`LMT_POS_HI:`LMT_POS_LO] == 3'(s)) begin
              dsl[s] = row_slot(dec_blk.row[r]);
              hit    = 1'b1;
            end else if (dec_blk.row[r][`LMT_POS_HI:`LMT_POS_LO] < 3'(s)) begin
              k = k + 4'h1;
            end
          end
        end
        if (!hit) begin
          di = ncr + 4'(s) - k;
          if (di > 4'h7) begin
            dbad = 1'b1;
          end else begin
            dsl[s].blk.pay = dec_blk.row[di[2:0]];
          end
        end
      end
    end
    if (dbad) begin
      for (int s = 0; s < 8; s++) begin
        dsl[s] = '{blk: ERR_BLK, mark: 1'b0, mask: 8'h00, otn: 8'h00};
      end
    end
  end

  // final block: scrambled payload, or marker with adjusted parity bytes
  always_comb begin
    emit_blk.sh  = cur.blk.sh;
    emit_blk.pay = e_scr[63:0];
    if (cur.mark) begin
      emit_blk.pay = {~adj_par, ~cur.blk.pay[23:0], adj_par, cur.blk.pay[23:0]};
    end
  end

  // per-lane bip sums, restarted from each marker of that lane
  for (genvar l = 0; l < 4; l++) begin : g_lane
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        ing_pcs[l] <= 8'h00;
        ing_otn[l] <= 8'h00;
        egr_pcs[l] <= 8'h00;
        egr_otn[l] <= 8'h00;
      end else begin
        if (take && in_lane == 2'(l)) begin
          ing_pcs[l] <= in_mark ? in_pfold : (ing_pcs[l] ^ in_pfold);
          ing_otn[l] <= in_mark ? in_ofold : (ing_otn[l] ^ in_ofold);
        end
        if (emit_go && e_lane == 2'(l)) begin
          egr_pcs[l] <= cur.mark ? e_pfold : (egr_pcs[l] ^ e_pfold);
          egr_otn[l] <= cur.mark ? e_ofold : (egr_otn[l] ^ e_ofold);
        end
      end
    end
  end

  // accept a 513b block, then emit its eight slots, at most one per cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= lmt_pkg::LMT_ST_IDLE;
      eidx     <= 3'h0;
      egr_lane <= 2'h0;
      scr      <= `LMT_SCR_SEED;
      dec_fail <= 1'b0;
      for (int s = 0; s < 8; s++) begin
        dslot[s] <= '0;
      end
    end else begin
      dec_fail <= dec_valid && dec_ready && dbad;
      unique case (state)
        lmt_pkg::LMT_ST_IDLE: begin
          if (dec_valid) begin
            dslot <= dsl;
            eidx  <= 3'h0;
            state <= lmt_pkg::LMT_ST_EMIT;
          end
        end
        lmt_pkg::LMT_ST_EMIT: begin
          if (emit_go) begin
            eidx     <= eidx + 3'h1;
            egr_lane <= e_lane + 2'h1;
            if (!cur.mark) begin
              scr <= e_scr[121:64];
            end
            if (eidx == 3'h7) begin
              state <= lmt_pkg::LMT_ST_IDLE;
            end
          end
        end
        default: state <= lmt_pkg::LMT_ST_IDLE;
      endcase
    end
  end

  // two-entry output buffer; a stalled receiver holds the emit machine
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fcnt    <= 2'h0;
      fwr     <= 1'b0;
      frd     <= 1'b0;
      fifo[0] <= '0;
      fifo[1] <= '0;
    end else begin
      if (emit_go) begin
        fifo[fwr] <= emit_blk;
        fwr       <= !fwr;
      end
      if (fpop) begin
        frd <= !frd;
      end
      fcnt <= fcnt + 2'(emit_go) - 2'(fpop);
    end
  end

endmodule

// ---- logic/lmt_regs.svh ----
// constants for the lane marker transcoder: codes, field positions, reset values
`ifndef LMT_REGS_SVH
`define LMT_REGS_SVH

// 66b sync header values
`define LMT_SH_DATA      2'h1
`define LMT_SH_CTRL      2'h2

// row_kind_code of a transported lane marker row
`define LMT_KIND_MARKER  4'h4

// row leading byte layout: more_rows_bit, slot_index_field, row_kind_code
`define LMT_MORE_BIT     7
`define LMT_POS_HI       6
`define LMT_POS_LO       4
`define LMT_KIND_HI      3

// error control block: type and eight seven-bit /E/ characters
`define LMT_ERR_TYPE     8'h1E
`define LMT_ERR_CHARS    {8{7'h1E}}

// lane tags, packed {tag_c, tag_b, tag_a}
`define LMT_TAG_LANE0    24'h477690
`define LMT_TAG_LANE1    24'hE6C4F0
`define LMT_TAG_LANE2    24'h9B65C5
`define LMT_TAG_LANE3    24'h3D79A2

// scrambler taps (1 + x^39 + x^58) and its reset seed
`define LMT_SCR_TAP_A    39
`define LMT_SCR_TAP_B    58
`define LMT_SCR_SEED     58'h3FF_FFFF_FFFF_FFFF

`endif

// ---- logic/lmt_pkg.sv ----
// types shared by the lane marker transcoder
package lmt_pkg;

  // one 66b block; byte k of the payload is pay[8k+7:8k]
  typedef struct packed {
    logic [1:0]  sh;
    logic [63:0] pay;
  } lmt_blk_t;

  // one 513b block; row 0 is the top row
  typedef struct packed {
    logic             flag;
    logic [7:0][63:0] row;
  } lmt_513_t;

  // one gathered or decoded slot with its marker side data
  typedef struct packed {
    lmt_blk_t   blk;
    logic       mark;
    logic [7:0] mask;
    logic [7:0] otn;
  } lmt_slot_t;

  // egress emit machine
  typedef enum logic [1:0] {
    LMT_ST_IDLE = 2'h0,
    LMT_ST_EMIT = 2'h1
  } lmt_state_t;

endpackage

// ---- verif/lmt_transcode_asserts.sv ----
// concurrent checks on the lane marker transcoder ports
`timescale 1ns/10ps
`include "lmt_regs.svh"
module lmt_transcode_chk (
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              in_valid,
  input wire logic              in_ready,
  input wire lmt_pkg::lmt_513_t enc_blk,
  input wire logic              enc_valid,
  input wire logic              enc_ready,
  input wire logic              ing_subst,
  input wire logic              dec_valid,
  input wire logic              dec_ready,
  input wire lmt_pkg::lmt_blk_t out_blk,
  input wire logic              out_valid,
  input wire logic              out_ready,
  input wire logic              dec_fail
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] take_cnt;                       // takes within the current group
  wire        take   = in_valid && in_ready;  // ingress handshake
  wire [23:0] r0_tag = enc_blk.row[0][31:8];  // tag bytes of the top row
  wire [23:0] o_tag  = out_blk.pay[23:0];     // tag bytes of an egress block
  // egress block that carries a known lane tag
  wire        o_mark = out_valid && out_blk.sh == `LMT_SH_CTRL && (o_tag == `LMT_TAG_LANE0 ||
                       o_tag == `LMT_TAG_LANE1 || o_tag == `LMT_TAG_LANE2 || o_tag == `LMT_TAG_LANE3);
  // count accepted ingress blocks modulo eight
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      take_cnt <= 3'h0;
    end else if (take) begin
      take_cnt <= take_cnt + 3'h1;
    end
  end
  a_ready_follow: assert property (in_ready == (!enc_valid || enc_ready)) else $error("in_ready wrong");
  a_enc_hold: assert property (enc_valid && !enc_ready |=> enc_valid && $stable(enc_blk))
    else $error("enc_blk not held");
  a_group_done: assert property (take && take_cnt == 3'h7 |=> enc_valid)
    else $error("no 513b block after eight takes");
  a_marker_row_tag: assert property (enc_valid && enc_blk.flag && enc_blk.row[0][3:0] == `LMT_KIND_MARKER |->
    r0_tag inside {`LMT_TAG_LANE0, `LMT_TAG_LANE1, `LMT_TAG_LANE2, `LMT_TAG_LANE3}) else $error("bad marker row tag");
  a_dec_busy: assert property (dec_valid && dec_ready |=> !dec_ready [*8])
    else $error("decoder took a block while emitting");
  a_fail_pulse: assert property (dec_fail |-> $past(dec_valid && dec_ready))
    else $error("dec_fail without a taken block");
  a_subst_pulse: assert property (ing_subst |-> $past(take))
    else $error("ing_subst without a taken block");
  a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_blk))
    else $error("out_blk not held");
  a_out_sync: assert property (out_valid |-> out_blk.sh inside {`LMT_SH_DATA, `LMT_SH_CTRL})
    else $error("bad egress sync header");
  a_marker_inverse: assert property (o_mark |-> out_blk.pay[55:32] == ~o_tag &&
    out_blk.pay[63:56] == ~out_blk.pay[31:24]) else $error("egress marker inverse bytes wrong");
  c_ctrl_block: cover property (enc_valid && enc_blk.flag);
  c_dec_fail: cover property (dec_fail);
  c_marker_out: cover property (o_mark);
  c_out_stall: cover property (out_valid && !out_ready);
endmodule

bind lmt_transcode lmt_transcode_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .in_valid(in_valid),
  .in_ready(in_ready), .enc_blk(enc_blk), .enc_valid(enc_valid), .enc_ready(enc_ready), .ing_subst(ing_subst),
  .dec_valid(dec_valid), .dec_ready(dec_ready), .out_blk(out_blk), .out_valid(out_valid), .out_ready(out_ready),
  .dec_fail(dec_fail));

// ---- verif/lmt_peer.sv ----
// far side model: otn link from encoder to decoder and a stalling pcs receiver
`timescale 1ns/10ps
module lmt_peer (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              stall,
  input  wire logic              corrupt,
  input  wire lmt_pkg::lmt_513_t enc_blk,
  input  wire logic              enc_valid,
  output logic                   enc_ready,
  output lmt_pkg::lmt_513_t      dec_blk,
  output logic                   dec_valid,
  input  wire logic              dec_ready,
  output logic                   out_ready
);
  logic [1:0] phase;  // stall pattern position
  // one block in flight on the link
  assign enc_ready = !dec_valid;
  // carry blocks across, spoil the top row when asked, throttle the receiver
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phase     <= 2'h0;
      out_ready <= 1'b0;
      dec_valid <= 1'b0;
      dec_blk   <= '0;
    end else begin
      phase     <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
      out_ready <= !stall || phase == 2'h2;
      if (dec_valid && dec_ready) begin
        dec_valid <= 1'b0;
        dec_blk   <= ~dec_blk;  // released lines show no stale block
      end else if (enc_valid && enc_ready) begin
        dec_valid <= 1'b1;
        dec_blk   <= corrupt ? {1'b1, enc_blk.row[7:1], enc_blk.row[0] | 64'h0F} : enc_blk;
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
// self-checking bench: ingress stimulus through the link model, egress and encoder checks
`timescale 1ns/10ps
`include "lmt_regs.svh"
module tb;
  logic              ref_clk;
  logic              rst_n;
  lmt_pkg::lmt_blk_t in_blk;
  logic [63:0]       in_raw_pay;
  logic              in_valid;
  logic              in_ready;
  lmt_pkg::lmt_513_t enc_blk;
  lmt_pkg::lmt_513_t dec_blk;
  lmt_pkg::lmt_blk_t out_blk;
  logic              enc_valid;
  logic              enc_ready;
  logic              ing_subst;
  logic              dec_valid;
  logic              dec_ready;
  logic              out_valid;
  logic              out_ready;
  logic              dec_fail;
  logic              stall;
  logic              corrupt;
  int                failures;
  int                comparisons;
  int                subst_seen;
  int                fail_seen;
  logic [65:0]       exp_q[$];  // expected egress blocks, descrambled and masked
  logic [63:0]       msk_q[$];  // compare mask, markers skip parity bytes
  lmt_pkg::lmt_513_t enc_q[$];  // encoder output as taken by the link
  logic [57:0]       dsc;       // egress descrambler state
  logic [63:0]       dpay;      // descrambled egress payload

  lmt_transcode uut (.ref_clk(ref_clk), .rst_n(rst_n), .in_blk(in_blk), .in_raw_pay(in_raw_pay),
    .in_valid(in_valid), .in_ready(in_ready), .enc_blk(enc_blk), .enc_valid(enc_valid), .enc_ready(enc_ready),
    .ing_subst(ing_subst), .dec_blk(dec_blk), .dec_valid(dec_valid), .dec_ready(dec_ready), .out_blk(out_blk),
    .out_valid(out_valid), .out_ready(out_ready), .dec_fail(dec_fail));
  lmt_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall), .corrupt(corrupt), .enc_blk(enc_blk),
    .enc_valid(enc_valid), .enc_ready(enc_ready), .dec_blk(dec_blk), .dec_valid(dec_valid),
    .dec_ready(dec_ready), .out_ready(out_ready));

  // 125 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // data payload pattern
  function automatic logic [63:0] dat(input int i);
    return {8{i[7:0]}} ^ 64'h0F1E_2D3C_4B5A_6978;
  endfunction

  // compare one value, report and count a mismatch
  task automatic check(input logic [65:0] seen, input logic [65:0] want);
    comparisons++;
    if (seen !== want) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // print counts and the verdict, then stop
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // offer one block, queue its expected egress form, hold until taken
  task automatic send(input logic [1:0] sh, input logic [63:0] pay, input logic [1:0] how);
    if (how == 2'h2) begin
      exp_q.push_back({`LMT_SH_CTRL, `LMT_ERR_CHARS, `LMT_ERR_TYPE});
      msk_q.push_back('1);
    end else if (how == 2'h1) begin
      exp_q.push_back({sh, pay & 64'h00FF_FFFF_00FF_FFFF});
      msk_q.push_back(64'h00FF_FFFF_00FF_FFFF);
    end else begin
      exp_q.push_back({sh, pay});
      msk_q.push_back('1);
    end
    in_blk     = {sh, pay};
    in_raw_pay = ~pay;
    in_valid   = 1'b1;
    for (int k = 0; k <= 200; k++) begin
      @(posedge ref_clk);
      if (in_ready === 1'b1) break;
      if (k == 200) begin
        failures++;
        test_done();
      end
    end
    #1;
  endtask

  // wait for the egress queue to empty and n encoder blocks to pass
  task automatic settle(input int n);
    in_valid = 1'b0;
    for (int k = 0; k <= 2000; k++) begin
      @(posedge ref_clk);
      if (exp_q.size() == 0 && enc_q.size() >= n) break;
      if (k == 2000) begin
        failures++;
        test_done();
      end
    end
    #1;
  endtask

  // record link traffic and pulses
  always @(posedge ref_clk) begin
    if (rst_n && enc_valid && enc_ready) enc_q.push_back(enc_blk);
    if (rst_n && ing_subst === 1'b1) subst_seen++;
    if (rst_n && dec_fail === 1'b1) fail_seen++;
  end

  // descramble each accepted egress block except markers and match it against the queue
  always @(posedge ref_clk) begin
    if (rst_n && out_valid === 1'b1 && out_ready) begin
      if (exp_q.size() == 0) begin
        exp_q.push_back('1);
        msk_q.push_back('1);
      end
      dpay = out_blk.pay;
      if (msk_q[0] == '1) begin
        for (int k = 0; k < 64; k++) begin
          dpay[k] = out_blk.pay[k] ^ dsc[38] ^ dsc[57];
          dsc     = {dsc[56:0], out_blk.pay[k]};
        end
      end
      check({out_blk.sh, dpay & msk_q[0]}, exp_q.pop_front());
      void'(msk_q.pop_front());
    end
  end

  // main sequence
  initial begin
    rst_n       = 1'b0;
    in_valid    = 1'b0;
    in_blk      = '0;
    in_raw_pay  = '0;
    stall       = 1'b0;
    corrupt     = 1'b0;
    failures    = 0;
    comparisons = 0;
    subst_seen  = 0;
    fail_seen   = 0;
    dsc         = '1;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    // all data group
    for (int i = 0; i < 8; i++) send(`LMT_SH_DATA, dat(i), 2'h0);
    // marker at slot 3, control at slot 5, receiver stalling
    stall = 1'b1;
    for (int i = 8; i < 11; i++) send(`LMT_SH_DATA, dat(i), 2'h0);
    send(`LMT_SH_CTRL, {~8'h5A, ~`LMT_TAG_LANE1, 8'h5A, `LMT_TAG_LANE1}, 2'h1);
    send(`LMT_SH_DATA, dat(11), 2'h0);
    send(`LMT_SH_CTRL, {56'h1122_3344_5566_77, 8'h1E}, 2'h0);
    for (int i = 12; i < 14; i++) send(`LMT_SH_DATA, dat(i), 2'h0);
    // invalid headers and an unknown control type
    send(2'h0, dat(14), 2'h2);
    send(2'h3, dat(15), 2'h2);
    send(`LMT_SH_CTRL, {56'hAB_CDEF_0123_4567, 8'h2D}, 2'h2);
    for (int i = 16; i < 21; i++) send(`LMT_SH_DATA, dat(i), 2'h0);
    settle(3);
    // spoiled 513b block, then a clean group
    corrupt = 1'b1;
    for (int i = 21; i < 29; i++) send(`LMT_SH_DATA, dat(i), 2'h2);
    settle(4);
    corrupt = 1'b0;
    stall   = 1'b0;
    for (int i = 29; i < 37; i++) send(`LMT_SH_DATA, dat(i), 2'h0);
    settle(5);
    check(66'(enc_q[0].flag), 66'h0);
    for (int i = 0; i < 8; i++) check(66'(enc_q[0].row[i]), 66'(dat(i)));
    for (int i = 2; i < 8; i++) check(66'(enc_q[1].row[i]), 66'(dat(i + 6)));
    check(66'(enc_q[1].flag), 66'h1);
    check(66'(enc_q[1].row[0][7:0]), 66'hB4);
    check(66'(enc_q[1].row[0][31:8]), 66'(`LMT_TAG_LANE1));
    check(66'(enc_q[1].row[1]), 66'h1122_3344_5566_7750);
    check(66'(enc_q[2].row[0][7:0]), 66'h80);
    check(66'(enc_q[2].row[2][7:0]), 66'h20);
    check(66'(subst_seen), 66'h3);
    check(66'(fail_seen), 66'h1);
    test_done();
  end
endmodule
